// [design/csr_core.sv]
/*
 * decode/execute of the shift-right, 64-bit subtract, trap return,
 * sleep entry and region jump group, with an apb register slave.
 * assumes operands come from the register file beside it, and that
 * leaving sleep is done only by power_on_restart (the async reset).
 */
// Operation
// - variable right shift uses source a low six
// - half shift moves right by 32 plus amount
// - 64-bit ops trap as reserved in 32-bit
// - trapping subtract writes a minus b
// - overflow traps and leaves destination untouched
// - wrapping subtract never traps on overflow
// - error level set: return to error pc
// - otherwise return to exception pc, clear level
// - trap return has no delay slot
// - system ops need system control access
// - sleep entry decoded from system control group
// - after writeback wait bus idle, stop clocks
// - only power_on_restart leaves sleep
// - region jump: top 36 bits (63:28), target shifted
// - call writes pc plus 8 to r31
`timescale 1ns/1ps
`default_nettype none
module csr_core
    import csr_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    input wire logic [63:0] instr_pc,
    input wire logic [63:0] source_a_val,
    input wire logic [63:0] source_b_val,
    input wire logic system_bus_busy,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output csr_wb_t wb_out,
    output logic [2:0] exc_cause,
    output logic redirect,
    output logic [63:0] redirect_pc,
    output logic squash_next,
    output logic clocks_stopped
);
    // fields of the incoming word
    logic [5:0] opc, fnc;
    logic [4:0] shift_amount_field, dest_field;
    logic [63:0] diff;
    logic carry62, carry63, ovf;
    logic mode64, sysok;
    logic [31:0] ctrl_r;
    logic [31:0] processor_state_reg;
    logic [63:0] exception_return_pc, error_return_pc;
    logic [63:0] pc_r;
    logic drain_req;
    logic bus_s1, bus_s2, bus_s3, bus_idle_r;
    csr_mode_t mode_r;
    logic run;

    assign opc = instr[31:26];
    assign fnc = instr[5:0];
    assign shift_amount_field = instr[10:6];
    assign dest_field = instr[15:11];
    assign mode64 = ctrl_r[CTRL_MODE64_BIT];
    assign sysok = ctrl_r[CTRL_SYSOK_BIT];
    assign run = clk_en && (mode_r == CSR_RUN) && instr_valid;

    // decode helpers used by several paths
    function automatic logic is_special(input logic [5:0] f,
                                        input logic [5:0] o,
                                        input logic [5:0] fn);
        return (o == OP_SPECIAL) && (fn == f);
    endfunction

    function automatic logic is_sys(input logic [31:0] w,
                                    input logic [5:0] fn);
        return (w[31:26] == OP_SYSCTL) && w[SYS_FN_FLAG_BIT]
            && (w[5:0] == fn);
    endfunction

    // carry out of bits 62 and 63 for a - b = a + ~b + 1
    logic [63:0] nb;
    logic [63:0] low_sum;
    logic [1:0] top_sum;
    assign nb = ~source_b_val;
    assign low_sum = {1'b0, source_a_val[62:0]} + {1'b0, nb[62:0]}
        + 64'h0000_0000_0000_0001;
    assign carry62 = low_sum[63];
    assign top_sum = {1'b0, source_a_val[63]} + {1'b0, nb[63]}
        + {1'b0, carry62};
    assign carry63 = top_sum[1];
    assign diff = {top_sum[0], low_sum[62:0]};
    assign ovf = carry62 ^ carry63;

    logic op_srlv, op_srl32, op_sub, op_subu, op_ret, op_sleep;
    logic op_j, op_jal, is64;
    assign op_srlv = is_special(FN_SRL_REG, opc, fnc);
    assign op_srl32 = is_special(FN_SRL_HALF, opc, fnc);
    assign op_sub = is_special(FN_SUB_TRAP, opc, fnc);
    assign op_subu = is_special(FN_SUB_WRAP, opc, fnc);
    assign op_ret = is_sys(instr, FN_RET_TRAP);
    assign op_sleep = is_sys(instr, FN_SLEEP);
    assign op_j = (opc == OP_JUMP);
    assign op_jal = (opc == OP_CALL);
    assign is64 = op_srlv | op_srl32 | op_sub | op_subu;

    // region target: top 36 bits (63:28) of the delay-slot address
    logic [63:0] slot_pc, region_pc;
    assign slot_pc = instr_pc + 64'h0000_0000_0000_0004;
    assign region_pc = {slot_pc[63:28], instr[25:0], 2'b00};

    // execute result and write-back
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wb_out <= '0;
            exc_cause <= EXC_NONE;
        end else if (clk_en) begin
            wb_out <= '0;
            exc_cause <= EXC_NONE;
            if (run) begin
                if (is64 && !mode64) begin
                    exc_cause <= EXC_RESERVED;
                end else if ((op_ret || op_sleep) && !sysok) begin
                    exc_cause <= EXC_COP_UNUSABLE;
                end else if (op_srlv) begin
                    wb_out <= '{1'b1, dest_field,
                        source_b_val >> source_a_val[5:0]};
                end else if (op_srl32) begin
                    wb_out <= '{1'b1, dest_field, source_b_val
                        >> (HALF_SHIFT + {1'b0, shift_amount_field})};
                end else if (op_sub && ovf) begin
                    exc_cause <= EXC_OVERFLOW;
                end else if (op_sub || op_subu) begin
                    wb_out <= '{1'b1, dest_field, diff};
                end else if (op_jal) begin
                    wb_out <= '{1'b1, LINK_REG,
                        instr_pc + LINK_OFFSET};
                end
            end
        end
    end

    // control flow changes
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            redirect <= 1'b0;
            redirect_pc <= '0;
            squash_next <= 1'b0;
            pc_r <= '0;
        end else if (clk_en) begin
            redirect <= 1'b0;
            squash_next <= 1'b0;
            if (run && (op_j || op_jal)) begin
                redirect <= 1'b1;
                redirect_pc <= region_pc;
                pc_r <= region_pc;
            end else if (run && op_ret && sysok) begin
                redirect <= 1'b1;
                squash_next <= 1'b1;
                if (processor_state_reg[ERR_LEVEL_BIT]) begin
                    redirect_pc <= error_return_pc;
                    pc_r <= error_return_pc;
                end else begin
                    redirect_pc <= exception_return_pc;
                    pc_r <= exception_return_pc;
                end
            end else if (run) begin
                pc_r <= instr_pc;
            end
        end
    end

    // processor state register: return clears one level bit
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            processor_state_reg <= STATE_RESET;
            exception_return_pc <= '0;
            error_return_pc <= '0;
        end else if (clk_en) begin
            if (run && op_ret && sysok) begin
                if (processor_state_reg[ERR_LEVEL_BIT])
                    processor_state_reg[ERR_LEVEL_BIT] <= 1'b0;
                else
                    processor_state_reg[EXC_LEVEL_BIT] <= 1'b0;
            end else if (psel && penable && pwrite) begin
                case (paddr)
                    REG_STATE: processor_state_reg <= pwdata;
                    REG_EPC_LO:
                        exception_return_pc <= {32'h0000_0000, pwdata};
                    REG_ERR_LO: error_return_pc <= {32'h0000_0000, pwdata};
                    default: ;
                endcase
            end
        end
    end

    // bus busy comes from outside: three-stage sync
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bus_s1 <= 1'b1;
            bus_s2 <= 1'b1;
            bus_s3 <= 1'b1;
            bus_idle_r <= 1'b0;
        end else if (clk_en) begin
            bus_s1 <= system_bus_busy;
            bus_s2 <= bus_s1;
            bus_s3 <= bus_s2;
            if (bus_s2 == bus_s3)
                bus_idle_r <= !bus_s3;
        end
    end

    // sleep sequencing; the only exit is reset
    assign drain_req = run && op_sleep && sysok;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mode_r <= CSR_RUN;
            clocks_stopped <= 1'b0;
        end else if (clk_en) begin
            case (mode_r)
                CSR_RUN: if (drain_req) mode_r <= CSR_DRAIN;
                // late stages must agree idle too: a transfer started
                // just before write-back is not cut short
                CSR_DRAIN: if (bus_idle_r && !bus_s2 && !bus_s3) begin
                    mode_r <= CSR_SLEEP;
                    clocks_stopped <= 1'b1;
                end
                CSR_SLEEP: clocks_stopped <= 1'b1;
                default: mode_r <= CSR_RUN;
            endcase
        end
    end

    // apb control register: mode and access bits
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= CTRL_RESET;
        end else if (clk_en && psel && penable && pwrite
                     && paddr == REG_CTRL) begin
            ctrl_r <= pwdata;
        end
    end

    // apb read side, zero wait states
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                case (paddr)
                    REG_CTRL: prdata <= ctrl_r;
                    REG_STATE: prdata <= processor_state_reg;
                    REG_STATUS: prdata <= {30'h0000_0000, mode_r};
                    REG_EPC_LO: prdata <= exception_return_pc[31:0];
                    REG_ERR_LO: prdata <= error_return_pc[31:0];
                    REG_PC_LO: prdata <= pc_r[31:0];
                    default: begin
                        prdata <= '0;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // checks
    property p_sub_ovf;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && run && op_sub && mode64 && ovf)
            |=> (exc_cause == EXC_OVERFLOW) && !wb_out.we;
    endproperty
    a_sub_ovf: assert property (p_sub_ovf)
        else $error("overflow not trapped");

    property p_wrap;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && run && op_subu && mode64)
            |=> wb_out.we && (wb_out.data == $past(diff));
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrapping subtract wrong");

    property p_res;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && run && is64 && !mode64) |=> exc_cause == EXC_RESERVED;
    endproperty
    a_res: assert property (p_res)
        else $error("reserved not raised");

    property p_srlv;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && run && op_srlv && mode64) |=> wb_out.data
            == ($past(source_b_val) >> $past(source_a_val[5:0]));
    endproperty
    a_srlv: assert property (p_srlv)
        else $error("variable shift wrong");

    property p_jal;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && run && op_jal) |=> wb_out.rd == LINK_REG
            && wb_out.data == $past(instr_pc) + LINK_OFFSET && redirect;
    endproperty
    a_jal: assert property (p_jal)
        else $error("link wrong");

    property p_ret;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && run && op_ret && sysok) |=> redirect && squash_next;
    endproperty
    a_ret: assert property (p_ret)
        else $error("return slot not squashed");

    property p_cop;
        @(posedge mclk) disable iff (!resetn)
        (clk_en && run && (op_ret || op_sleep) && !sysok)
            |=> exc_cause == EXC_COP_UNUSABLE && !redirect;
    endproperty
    a_cop: assert property (p_cop)
        else $error("unusable not raised");

    sequence s_drain;
        mode_r == CSR_DRAIN;
    endsequence
    property p_sleep;
        @(posedge mclk) disable iff (!resetn)
        (mode_r == CSR_SLEEP) |=> (mode_r == CSR_SLEEP) && clocks_stopped;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("left sleep without reset");

    property p_enter;
        @(posedge mclk) disable iff (!resetn)
        s_drain and (bus_idle_r && !bus_s2 && !bus_s3 && clk_en)
            |=> mode_r == CSR_SLEEP;
    endproperty
    a_enter: assert property (p_enter)
        else $error("sleep not entered");

    property p_hold;
        @(posedge mclk) disable iff (!resetn)
        s_drain and (bus_s2 || bus_s3) |=> s_drain;
    endproperty
    a_hold: assert property (p_hold)
        else $error("slept on a busy bus");
endmodule
`default_nettype wire

// [design/csr_pkg.sv]
/*
 * package for the shift/subtract/return/jump decoder: opcode fields,
 * function codes, state bit positions, apb offsets and reset values.
 * assumes a 32-bit apb master and a 125 mhz core clock.
 */
package csr_pkg;
    // instruction fields
    localparam logic [5:0] OP_SPECIAL = 6'h00;
    localparam logic [5:0] OP_JUMP = 6'h02;
    localparam logic [5:0] OP_CALL = 6'h03;
    localparam logic [5:0] OP_SYSCTL = 6'h10;
    localparam logic [5:0] FN_SRL_REG = 6'h16;
    localparam logic [5:0] FN_SRL_HALF = 6'h3e;
    localparam logic [5:0] FN_SUB_TRAP = 6'h2e;
    localparam logic [5:0] FN_SUB_WRAP = 6'h2f;
    localparam logic [5:0] FN_RET_TRAP = 6'h18;
    localparam logic [5:0] FN_SLEEP = 6'h23;
    localparam int SYS_FN_FLAG_BIT = 25;
    localparam logic [4:0] LINK_REG = 5'h1f;
    localparam logic [63:0] LINK_OFFSET = 64'h0000_0000_0000_0008;
    localparam logic [5:0] HALF_SHIFT = 6'h20;
    // processor state bits
    localparam int EXC_LEVEL_BIT = 1;
    localparam int ERR_LEVEL_BIT = 2;
    // exception causes
    localparam logic [2:0] EXC_NONE = 3'h0;
    localparam logic [2:0] EXC_RESERVED = 3'h1;
    localparam logic [2:0] EXC_OVERFLOW = 3'h2;
    localparam logic [2:0] EXC_COP_UNUSABLE = 3'h3;
    // apb map
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATE = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam logic [11:0] REG_EPC_LO = 12'h00c;
    localparam logic [11:0] REG_ERR_LO = 12'h010;
    localparam logic [11:0] REG_PC_LO = 12'h014;
    localparam int CTRL_MODE64_BIT = 0;
    localparam int CTRL_SYSOK_BIT = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
    localparam logic [31:0] STATE_RESET = 32'h0000_0000;

    typedef struct packed {
        logic we;
        logic [4:0] rd;
        logic [63:0] data;
    } csr_wb_t;

    typedef enum logic [1:0] {
        CSR_RUN = 2'b00,
        CSR_DRAIN = 2'b01,
        CSR_SLEEP = 2'b10
    } csr_mode_t;
endpackage

// [tb/csr_bus_model.sv]
/*
 * system bus model for the core's sleep handshake: raises
 * system_bus_busy for a set number of cycles after each kick.
 * assumes the bench pulses kick for one cycle at a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module csr_bus_model
    import csr_pkg::*;
#(
    parameter int BUSY_LEN = 10
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic kick,
    output logic system_bus_busy
);
    int cnt_r;
    // transfer in flight, counted down to idle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 0;
        end else if (kick) begin
            cnt_r <= BUSY_LEN;
        end else if (cnt_r != 0) begin
            cnt_r <= cnt_r - 1;
        end
    end
    // busy until the last beat, so sleep must wait for it
    assign system_bus_busy = (cnt_r != 0);
endmodule
`default_nettype wire

// [tb/cpu_shift_sub_return_jump_ops_bench.sv]
/*
 * self-checking bench: apb and instruction tasks, expected results
 * built from the instruction semantics. assumes csr_pkg and csr_core.
 */
`timescale 1ns/1ps
`default_nettype none
module cpu_shift_sub_return_jump_ops_bench
    import csr_pkg::*;
;
    logic mclk = 0, resetn = 0, instr_valid = 0, kick = 0;
    logic psel = 0, penable = 0, pwrite = 0;
    logic pready, pslverr, redirect, squash_next, clocks_stopped, busy;
    logic [11:0] paddr = '0;
    logic [31:0] instr = '0, pwdata = '0, prdata;
    logic [63:0] instr_pc = '0, a = '0, b = '0, redirect_pc;
    logic [2:0] exc_cause;
    csr_wb_t wb_out;
    int error_cnt = 0, n_checks = 0;

    csr_core dut (.mclk(mclk), .resetn(resetn), .clk_en(1'b1),
        .instr_valid(instr_valid), .instr(instr), .instr_pc(instr_pc),
        .source_a_val(a), .source_b_val(b), .system_bus_busy(busy),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wb_out(wb_out), .exc_cause(exc_cause),
        .redirect(redirect), .redirect_pc(redirect_pc),
        .squash_next(squash_next), .clocks_stopped(clocks_stopped));
    csr_bus_model #(.BUSY_LEN(10)) bus (.mclk(mclk), .resetn(resetn),
        .kick(kick), .system_bus_busy(busy));

    // 125 mhz core clock
    initial begin
        forever #4 mclk = ~mclk;
    end

    task automatic conclude();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic fail(input string m);
        error_cnt++;
        $display("ERROR %0t %s", $time, m);
    endtask

    task automatic chk_reg(input logic [31:0] got, exp, input string m);
        n_checks++;
        if (got !== exp) fail(m);
    endtask

    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] ad,
        input logic [31:0] wd, output logic [31:0] rd, output logic er);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail("apb no ready");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, ad, d, rd, er);
    endtask

    task automatic rdchk(input logic [11:0] ad, input logic [31:0] e);
        logic [31:0] rd;
        logic er;
        apb(1'b0, ad, 32'h0000_0000, rd, er);
        chk_reg(rd, e, "register read");
        chk_reg({31'h0, er}, {31'h0, ad > 12'h014}, "slave error");
    endtask

    // present one instruction, then look at the answer cycle
    task automatic exec(input logic [31:0] i, input logic [63:0] pc, ra,
        input logic [63:0] rb);
        @(posedge mclk);
        instr_valid <= 1'b1;
        instr <= i;
        instr_pc <= pc;
        a <= ra;
        b <= rb;
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
    endtask

    task automatic chk_out(input logic we, input logic [4:0] rd,
        input logic [63:0] d, input logic [2:0] ex, input logic rr,
        input logic [63:0] rp, input logic sq);
        n_checks++;
        if (wb_out.we !== we || exc_cause !== ex || redirect !== rr ||
            squash_next !== sq) fail("control outputs");
        else if (we && (wb_out.rd !== rd || wb_out.data !== d))
            fail("write back");
        else if (rr && redirect_pc !== rp) fail("redirect pc");
    endtask

    function automatic logic [31:0] sp(input logic [4:0] rd, sa,
        input logic [5:0] fn);
        return {OP_SPECIAL, 10'h000, rd, sa, fn};
    endfunction

    function automatic logic [31:0] sys(input logic [5:0] fn);
        return {OP_SYSCTL, 1'b1, 19'h0_0000, fn};
    endfunction

    // hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        fail("timeout");
        conclude();
    end

    // test sequence
    initial begin
        logic [63:0] v, pc, j;
        logic [25:0] t;
        logic [2:0] e;
        logic [5:0] fns [4];
        fns = '{FN_SRL_REG, FN_SRL_HALF, FN_SUB_TRAP, FN_SUB_WRAP};
        v = 64'hf123_4567_89ab_cdef;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        rdchk(REG_CTRL, CTRL_RESET);
        rdchk(REG_STATE, STATE_RESET);
        rdchk(12'h100, 32'h0000_0000);
        for (int s = 0; s < 130; s += 43) begin
            exec(sp(5'h03, 5'h00, FN_SRL_REG), '0, 64'(s), v);
            chk_out(1, 5'h03, v >> s[5:0], EXC_NONE, 0, 0, 0);
        end
        for (int s = 0; s < 32; s += 31) begin
            exec(sp(5'h04, 5'(s), FN_SRL_HALF), '0, '0, v);
            chk_out(1, 5'h04, v >> (32 + s), EXC_NONE, 0, 0, 0);
        end
        for (int k = 0; k < 2; k++) begin
            pc = k ? 64'h8000_0000_0000_0000 : 64'h0000_0000_0000_0005;
            exec(sp(5'h05, 5'h00, FN_SUB_TRAP), '0, pc, 64'h7);
            e = k ? EXC_OVERFLOW : EXC_NONE;
            chk_out(!k, 5'h05, pc - 64'h7, e, 0, 0, 0);
            exec(sp(5'h06, 5'h00, FN_SUB_WRAP), '0, pc, 64'h7);
            chk_out(1, 5'h06, pc - 64'h7, EXC_NONE, 0, 0, 0);
        end
        wr(REG_CTRL, 32'h0000_0002);
        foreach (fns[i]) begin
            exec(sp(5'h07, 5'h01, fns[i]), '0, 64'h1, v);
            chk_out(0, 0, 0, EXC_RESERVED, 0, 0, 0);
        end
        wr(REG_CTRL, 32'h0000_0001);
        exec(sys(FN_RET_TRAP), '0, '0, '0);
        chk_out(0, 0, 0, EXC_COP_UNUSABLE, 0, 0, 0);
        exec(sys(FN_SLEEP), '0, '0, '0);
        chk_out(0, 0, 0, EXC_COP_UNUSABLE, 0, 0, 0);
        wr(REG_CTRL, CTRL_RESET);
        wr(REG_ERR_LO, 32'h0000_1000);
        wr(REG_EPC_LO, 32'h0000_2000);
        wr(REG_STATE, 32'h0000_0007);
        exec(sys(FN_RET_TRAP), '0, '0, '0);
        chk_out(0, 0, 0, EXC_NONE, 1, 64'h1000, 1);
        rdchk(REG_STATE, 32'h0000_0003);
        exec(sys(FN_RET_TRAP), '0, '0, '0);
        chk_out(0, 0, 0, EXC_NONE, 1, 64'h2000, 1);
        rdchk(REG_STATE, 32'h0000_0001);
        rdchk(REG_PC_LO, 32'h0000_2000);
        rdchk(REG_EPC_LO, 32'h0000_2000);
        rdchk(REG_ERR_LO, 32'h0000_1000);
        // delay slot crosses a 256 mb region boundary
        pc = 64'h0000_0000_0fff_fffc;
        t = 26'h123_4567;
        j = pc + 64'h4;
        j = {j[63:28], t, 2'b00};
        exec({OP_JUMP, t}, pc, '0, '0);
        chk_out(0, 0, 0, EXC_NONE, 1, j, 0);
        exec({OP_CALL, t}, pc, '0, '0);
        chk_out(1, 5'h1f, pc + 64'h8, EXC_NONE, 1, j, 0);
        // sleep entry must wait out a busy bus
        @(posedge mclk);
        kick <= 1'b1;
        @(posedge mclk);
        kick <= 1'b0;
        exec(sys(FN_SLEEP), '0, '0, '0);
        chk_out(0, 0, 0, EXC_NONE, 0, 0, 0);
        while (busy === 1'b1) begin
            chk_reg({31'h0, clocks_stopped}, 32'h0, "early stop");
            @(posedge mclk);
        end
        for (int n = 0; n < 20 && clocks_stopped !== 1'b1; n++)
            @(posedge mclk);
        chk_reg({31'h0, clocks_stopped}, 32'h1, "no stop");
        exec(sp(5'h03, 5'h00, FN_SRL_REG), '0, '0, v);
        chk_out(0, 0, 0, EXC_NONE, 0, 0, 0);
        chk_reg({31'h0, clocks_stopped}, 32'h1, "woke");
        rdchk(REG_STATUS, 32'(CSR_SLEEP));
        // cold restart is the only way out
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        chk_reg({31'h0, clocks_stopped}, 32'h0, "stuck");
        rdchk(REG_STATUS, 32'h0000_0000);
        conclude();
    end
endmodule
`default_nettype wire
